// *** design/adc_output_ctrl.sv ***
// Converter digital side: format select, clock supervision, output word and AXI4-Lite registers
//
// Function
// - stabilizer samples on rising edge only
// - stabilizer accepts 40 to 60 percent duty
// - about hundred edges relock; samples invalid meanwhile
// - 14-bit word plus one overrange flag
// - offset binary: midscale top bit, linear steps
// - two's complement: offset binary, top bit inverted
// - overrange sets flag, word clamps to extreme
// - four-level pin picks format and stabilizer
// - disable pin high floats all data outputs
// - nap or sleep floats outputs; 100-edge recovery from nap, SLEEP_RECOVER_CYCLES (10000) edges from sleep
// - without stabilizer, rising edge ends sampling
`timescale 1ns/10ps
module adc_output_ctrl
  import adc_fmt_pkg::*;
#(
  parameter int GRADE_MSPS           = 65,
  parameter int SLEEP_RECOVER_CYCLES = 10000
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              sample_clk,
  input  wire logic [1:0]        mode_level,
  input  wire logic              power_down_select,
  input  wire logic              output_enable_n,
  input  wire logic [WORD_W-1:0] conv_code,
  input  wire logic              conv_over,
  input  wire logic              conv_under,
  output logic [WORD_W-1:0]      sample_word_bits,
  output logic                   sample_word_bits_oe,
  output logic                   overrange_flag,
  output logic                   overrange_flag_oe,
  output logic                   sample_valid,
  output logic                   irq
);
  // ==========================================================
  // Timing figures
  localparam int MIN_PHASE_PS   = (GRADE_MSPS >= 65) ? MIN_PHASE_PS_65 :
                                  (GRADE_MSPS >= 40) ? MIN_PHASE_PS_40 : MIN_PHASE_PS_25;
  localparam int MIN_PHASE_RAW  = (MIN_PHASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_PHASE_CYC  = (MIN_PHASE_RAW < 1) ? 1 : MIN_PHASE_RAW;
  localparam int MIN_PERIOD_PS  = PS_PER_US / GRADE_MSPS;
  localparam int MIN_PERIOD_RAW = (MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_PERIOD_CYC = (MIN_PERIOD_RAW < 1) ? 1 : MIN_PERIOD_RAW;
  localparam int MAX_PERIOD_CYC = (PS_PER_US / MIN_RATE_MSPS) / CLK_PERIOD_PS;
  localparam int STOP_CYC       = (STOP_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

  localparam logic [15:0] PHASE_MIN_C  = 16'(MIN_PHASE_CYC);
  localparam logic [15:0] PERIOD_MIN_C = 16'(MIN_PERIOD_CYC);
  localparam logic [15:0] PERIOD_MAX_C = 16'(MAX_PERIOD_CYC);
  localparam logic [15:0] PCT_C        = 16'(PCT_FULL);
  localparam logic [15:0] DUTY_LO_C    = 16'(DUTY_NOM_PCT - DUTY_TOL_PCT);
  localparam logic [15:0] DUTY_HI_C    = 16'(DUTY_NOM_PCT + DUTY_TOL_PCT);
  localparam logic [15:0] SDUTY_LO_C   = 16'(STAB_DUTY_MIN_PCT);
  localparam logic [15:0] SDUTY_HI_C   = 16'(STAB_DUTY_MAX_PCT);
  localparam logic [RCV_W-1:0] RELOCK_C    = RCV_W'(RELOCK_EDGES);
  localparam logic [RCV_W-1:0] NAP_RCV_C   = RCV_W'(NAP_RECOVER_EDGES);
  localparam logic [RCV_W-1:0] SLEEP_RCV_C = RCV_W'(SLEEP_RECOVER_CYCLES);

  // ==========================================================
  // State
  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [INT_W-1:0]  int_status;
    logic [INT_W-1:0]  int_mask;
    pwr_e              pwr;
    logic [RCV_W-1:0]  recover;
    logic [RCV_W-1:0]  relock;
    logic              stab_prev;
    logic              oe;
    logic              valid;
  } state_s;
  state_s state_reg;
  state_s state_next;

  logic        rise;
  phase_s      meas;
  logic        meas_strobe;
  logic        stopped;
  sample_bus_s coded;
  logic [1:0]  mode_eff;
  logic        twos;
  logic        stab_on;
  logic        duty_err;
  logic        phase_err;
  logic        rate_err;
  logic [15:0] high_w;
  logic [15:0] low_w;
  logic [15:0] period_w;
  logic [INT_W-1:0] events;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;

  // ==========================================================
  // Clock watcher and word coder
  clk_phase_monitor #(
    .STOP_CYCLES (STOP_CYC)
  ) u_mon (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sample_clk  (sample_clk),
    .rise        (rise),
    .meas        (meas),
    .meas_strobe (meas_strobe),
    .stopped     (stopped)
  );

  // Only the rising edge loads a word, in both stabilizer settings
  format_coder u_coder (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load      (rise & (state_reg.pwr == PWR_RUN)),
    .twos      (twos),
    .raw_code  (conv_code),
    .raw_over  (conv_over),
    .raw_under (conv_under),
    .coded     (coded)
  );

  // ==========================================================
  // Mode pin decode, optionally overridden from software
  always_comb
  begin
    mode_eff = state_reg.ctrl[CTRL_OVR_EN] ? state_reg.ctrl[CTRL_MODE_LSB +: 2] : mode_level;
    case (mode_level_e'(mode_eff))
      MODE_GND:        begin twos = 1'b0; stab_on = 1'b0; end
      MODE_THIRD:      begin twos = 1'b0; stab_on = 1'b1; end
      MODE_TWO_THIRDS: begin twos = 1'b1; stab_on = 1'b1; end
      MODE_SUPPLY:     begin twos = 1'b1; stab_on = 1'b0; end
      default:         begin twos = 1'b0; stab_on = 1'b0; end
    endcase
  end

  // ==========================================================
  // Clock supervision
  always_comb
  begin
    high_w   = 16'(meas.high);
    low_w    = 16'(meas.low);
    period_w = high_w + low_w;
    if (stab_on)
      duty_err = (high_w * PCT_C < period_w * SDUTY_LO_C) ||
                 (high_w * PCT_C > period_w * SDUTY_HI_C);
    else
      duty_err = (high_w * PCT_C < period_w * DUTY_LO_C) ||
                 (high_w * PCT_C > period_w * DUTY_HI_C);
    // The falling edge is regenerated internally when stabilized
    phase_err = (high_w < PHASE_MIN_C) || (!stab_on && low_w < PHASE_MIN_C);
    rate_err  = (period_w < PERIOD_MIN_C) || (period_w > PERIOD_MAX_C);
  end

  // Events are one-cycle pulses; int_status keeps them until software clears them
  always_comb
  begin
    events                = '0;
    events[INT_OVERRANGE] = rise && state_reg.pwr == PWR_RUN && (conv_over || conv_under);
    events[INT_CLK_STOP]  = stopped && state_reg.relock == '0 && stab_on;
    events[INT_DUTY]      = meas_strobe && (duty_err || phase_err);
    events[INT_RATE]      = meas_strobe && rate_err;
    events[INT_LOCKED]    = rise && state_reg.relock == RCV_W'(1);
  end

  // ==========================================================
  // Register bus
  // A held address or data word blocks the next one until its write completes
  assign awready = !state_reg.aw_held;
  assign wready  = !state_reg.w_held;
  assign arready = !state_reg.rvalid;
  assign wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign rd_fire = arvalid && !state_reg.rvalid;
  assign wr_hit  = state_reg.aw_addr == CTRL_OFS || state_reg.aw_addr == INT_STATUS_OFS ||
                   state_reg.aw_addr == INT_MASK_OFS;

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = '0;
    case (araddr)
      CTRL_OFS:       rd_word[CTRL_W-1:0] = state_reg.ctrl;
      STATUS_OFS:     rd_word[7:0] = {state_reg.valid, stopped, state_reg.relock != '0,
                                      state_reg.pwr, stab_on, twos};
      INT_STATUS_OFS: rd_word[INT_W-1:0] = state_reg.int_status;
      INT_MASK_OFS:   rd_word[INT_W-1:0] = state_reg.int_mask;
      SAMPLE_OFS:     rd_word[WORD_W:0] = coded;
      PHASE_OFS:      rd_word[2*CNT_W-1:0] = meas;
      default:        rd_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    state_next = state_reg;
    if (awvalid && awready)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      state_next.w_held = 1'b1;
      state_next.w_data = wdata;
      state_next.w_strb = wstrb;
    end
    if (bvalid && bready)
      state_next.bvalid = 1'b0;
    if (rvalid && rready)
      state_next.rvalid = 1'b0;

    // Set wins over a same-cycle write-one clear
    if (wr_fire && state_reg.aw_addr == INT_STATUS_OFS && state_reg.w_strb[0])
      state_next.int_status = state_reg.int_status & ~state_reg.w_data[INT_W-1:0];
    state_next.int_status = state_next.int_status | events;

    if (wr_fire)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (state_reg.w_strb[0] && state_reg.aw_addr == CTRL_OFS)
        state_next.ctrl = state_reg.w_data[CTRL_W-1:0];
      if (state_reg.w_strb[0] && state_reg.aw_addr == INT_MASK_OFS)
        state_next.int_mask = state_reg.w_data[INT_W-1:0];
    end
    if (rd_fire)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_word;
      state_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Power modes; returning to run from nap or sleep starts a recovery count
    case (state_reg.pwr)
      PWR_RUN:
        if (power_down_select)
          state_next.pwr = output_enable_n ? PWR_SLEEP : PWR_NAP;
      PWR_NAP:
        if (!power_down_select)
        begin
          state_next.pwr     = PWR_RUN;
          state_next.recover = NAP_RCV_C;
        end
        else if (output_enable_n)
          state_next.pwr = PWR_SLEEP;
      PWR_SLEEP:
        if (!power_down_select)
        begin
          state_next.pwr     = PWR_RUN;
          state_next.recover = SLEEP_RCV_C;
        end
        else if (!output_enable_n)
          state_next.pwr = PWR_NAP;
      default:
        state_next.pwr = PWR_RUN;
    endcase
    if (state_reg.pwr == PWR_RUN && state_reg.recover != '0 && rise)
      state_next.recover = state_reg.recover - 1'b1;

    // Stabilizer relock after a stopped clock or on being switched on
    state_next.stab_prev = stab_on;
    if (!stab_on)
      state_next.relock = '0;
    else if (stopped || !state_reg.stab_prev)
      state_next.relock = RELOCK_C;
    else if (rise && state_reg.relock != '0)
      state_next.relock = state_reg.relock - 1'b1;

    // Floating the pins is meant for long idle periods only
    state_next.oe    = !output_enable_n && state_next.pwr == PWR_RUN;
    state_next.valid = state_next.pwr == PWR_RUN && state_next.recover == '0 &&
                       state_next.relock == '0 && !stopped;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg            <= '0;
      state_reg.ctrl       <= CTRL_RESET;
      state_reg.int_status <= INT_RESET;
      state_reg.int_mask   <= INT_RESET;
      state_reg.pwr        <= PWR_RUN;
    end
    else
      state_reg <= state_next;
  end

  // ==========================================================
  // Outputs
  assign bvalid              = state_reg.bvalid;
  assign bresp               = state_reg.bresp;
  assign rvalid              = state_reg.rvalid;
  assign rresp               = state_reg.rresp;
  assign rdata               = state_reg.rdata;
  assign sample_word_bits    = coded.word;
  assign overrange_flag      = coded.over;
  assign sample_word_bits_oe = state_reg.oe;
  assign overrange_flag_oe   = state_reg.oe;
  assign sample_valid        = state_reg.valid;
  assign irq                 = |(state_reg.int_status & state_reg.int_mask);
endmodule

// *** include/adc_fmt_pkg.sv ***
// Shared constants, encodings and carriers of the converter output block
package adc_fmt_pkg;
  // ==========================================================
  // Data word and timing
  localparam int           WORD_W            = 14;
  localparam int           SIGN_BIT          = 13;
  localparam logic [13:0]  CODE_FULL_POS     = 14'h3FFF;
  localparam logic [13:0]  CODE_FULL_NEG     = 14'h0000;
  localparam int           CLK_PERIOD_PS     = 40000;
  localparam int           MIN_PHASE_PS_65   = 7300;
  localparam int           MIN_PHASE_PS_40   = 11800;
  localparam int           MIN_PHASE_PS_25   = 18900;
  localparam int           MIN_RATE_MSPS     = 1;
  localparam int           PS_PER_US         = 1000000;
  localparam int           DUTY_NOM_PCT      = 50;
  localparam int           DUTY_TOL_PCT      = 5;
  localparam int           STAB_DUTY_MIN_PCT = 40;
  localparam int           STAB_DUTY_MAX_PCT = 60;
  localparam int           PCT_FULL          = 100;
  localparam int           RELOCK_EDGES      = 100;
  localparam int           NAP_RECOVER_EDGES = 100;
  localparam int           STOP_TIMEOUT_NS   = 4000;
  localparam int           CNT_W             = 8;
  localparam int           RCV_W             = 16;
  // ==========================================================
  // Register map
  localparam int           ADDR_W            = 8;
  localparam logic [7:0]   CTRL_OFS          = 8'h00;
  localparam logic [7:0]   STATUS_OFS        = 8'h04;
  localparam logic [7:0]   INT_STATUS_OFS    = 8'h08;
  localparam logic [7:0]   INT_MASK_OFS      = 8'h0C;
  localparam logic [7:0]   SAMPLE_OFS        = 8'h10;
  localparam logic [7:0]   PHASE_OFS         = 8'h14;
  localparam int           CTRL_W            = 3;
  localparam int           CTRL_OVR_EN       = 0;
  localparam int           CTRL_MODE_LSB     = 1;
  localparam logic [2:0]   CTRL_RESET        = 3'h0;
  localparam int           INT_W             = 5;
  localparam int           INT_OVERRANGE     = 0;
  localparam int           INT_CLK_STOP      = 1;
  localparam int           INT_DUTY          = 2;
  localparam int           INT_RATE          = 3;
  localparam int           INT_LOCKED        = 4;
  localparam logic [4:0]   INT_RESET         = 5'h00;
  localparam logic [1:0]   RESP_OKAY         = 2'h0;
  localparam logic [1:0]   RESP_SLVERR       = 2'h2;
  // ==========================================================
  // Encodings and carriers
  typedef enum logic [1:0] {
    MODE_GND        = 2'h0,
    MODE_THIRD      = 2'h1,
    MODE_TWO_THIRDS = 2'h2,
    MODE_SUPPLY     = 2'h3
  } mode_level_e;
  typedef enum logic [2:0] {
    PWR_RUN   = 3'b001,
    PWR_NAP   = 3'b010,
    PWR_SLEEP = 3'b100
  } pwr_e;
  typedef struct packed {
    logic              over;
    logic [WORD_W-1:0] word;
  } sample_bus_s;
  typedef struct packed {
    logic [CNT_W-1:0] low;
    logic [CNT_W-1:0] high;
  } phase_s;
endpackage

// *** design/format_coder.sv ***
// Output word coder: clamping on overrange and offset-binary or two's-complement coding
`timescale 1ns/10ps
module format_coder
  import adc_fmt_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              load,
  input  wire logic              twos,
  input  wire logic [WORD_W-1:0] raw_code,
  input  wire logic              raw_over,
  input  wire logic              raw_under,
  output sample_bus_s            coded
);
  typedef struct packed {
    sample_bus_s q;
  } state_s;
  state_s state_reg;
  state_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (load)
    begin
      if (raw_over)
        state_next.q.word = CODE_FULL_POS;
      else if (raw_under)
        state_next.q.word = CODE_FULL_NEG;
      else
        state_next.q.word = raw_code;
      state_next.q.over = raw_over | raw_under;
      if (twos)
        state_next.q.word[SIGN_BIT] = ~state_next.q.word[SIGN_BIT];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign coded = state_reg.q;
endmodule

// *** design/clk_phase_monitor.sv ***
// Sample clock watcher: edge detect, high and low phase lengths, stop detection
`timescale 1ns/10ps
module clk_phase_monitor
  import adc_fmt_pkg::*;
#(
  parameter int STOP_CYCLES = 100
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic sample_clk,
  output logic      rise,
  output phase_s    meas,
  output logic      meas_strobe,
  output logic      stopped
);
  typedef struct packed {
    logic             prev;
    logic [CNT_W-1:0] hcnt;
    logic [CNT_W-1:0] lcnt;
    logic [CNT_W-1:0] idle;
    logic             seen;
    logic             stopped;
    logic             strobe;
    phase_s           meas;
  } state_s;
  state_s state_reg;
  state_s state_next;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [CNT_W-1:0] STOP_C  = CNT_W'(STOP_CYCLES);

  assign rise = sample_clk & ~state_reg.prev;

  always_comb
  begin
    state_next        = state_reg;
    state_next.prev   = sample_clk;
    state_next.strobe = 1'b0;
    if (sample_clk != state_reg.prev)
      state_next.idle = '0;
    else if (state_reg.idle != CNT_MAX)
      state_next.idle = state_reg.idle + 1'b1;
    if (state_reg.idle >= STOP_C)
      state_next.stopped = 1'b1;
    if (rise)
    begin
      // A full period is known only once a high phase has been counted
      state_next.meas.high = state_reg.hcnt;
      state_next.meas.low  = state_reg.lcnt;
      state_next.strobe    = state_reg.seen & ~state_reg.stopped;
      state_next.seen      = 1'b1;
      state_next.stopped   = 1'b0;
      state_next.hcnt      = CNT_W'(1);
    end
    else if (sample_clk && state_reg.hcnt != CNT_MAX)
      state_next.hcnt = state_reg.hcnt + 1'b1;
    if (!sample_clk && state_reg.prev)
      state_next.lcnt = CNT_W'(1);
    else if (!sample_clk && state_reg.lcnt != CNT_MAX)
      state_next.lcnt = state_reg.lcnt + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign meas        = state_reg.meas;
  assign meas_strobe = state_reg.strobe;
  assign stopped     = state_reg.stopped;
endmodule

// *** test/adc_output_checker.sv ***
// Port assertions for the converter output block
`timescale 1ns/10ps
module adc_output_checker
  import adc_fmt_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic              rvalid,
  input wire logic              power_down_select,
  input wire logic              output_enable_n,
  input wire logic [WORD_W-1:0] sample_word_bits,
  input wire logic              sample_word_bits_oe,
  input wire logic              overrange_flag,
  input wire logic              overrange_flag_oe,
  input wire logic              sample_valid
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence write_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence read_taken;
    arvalid && arready;
  endsequence
  a_oe_disable: assert property (output_enable_n |=> !sample_word_bits_oe && !overrange_flag_oe)
    else $error("outputs still driven after disable");
  // Two cycles of power down give the power state register time to settle
  a_nap_float: assert property (power_down_select [*2] |=> !sample_word_bits_oe && !sample_valid)
    else $error("outputs active in power down");
  a_flag_oe_pair: assert property (overrange_flag_oe == sample_word_bits_oe)
    else $error("flag and word enables differ");
  a_clamp_extreme: assert property (overrange_flag |-> (sample_word_bits[12:0] == 13'h1FFF
    || sample_word_bits[12:0] == 13'h0000))
    else $error("overrange word not at an extreme code");
  a_read_answer: assert property (read_taken |=> rvalid)
    else $error("read data late");
  a_write_answer: assert property (write_taken |-> ##[1:2] bvalid)
    else $error("write response late");
  a_arready_excl: assert property (arready == !rvalid)
    else $error("read address ready while data pending");
  a_resp_legal: assert property (bvalid |-> (bresp == RESP_OKAY || bresp == RESP_SLVERR))
    else $error("illegal write response code");
endmodule

// *** test/capture_model.sv ***
// Capture logic model: latches the sample word on the falling sample clock edge
`timescale 1ns/10ps
module capture_model
  import adc_fmt_pkg::*;
(
  input  wire logic              sample_clk,
  input  wire logic [WORD_W-1:0] bus_word,
  input  wire logic              bus_flag,
  input  wire logic              bus_oe,
  input  wire logic              valid,
  output sample_bus_s            cap,
  output logic                   cap_ok
);
  // ==========================================================
  // Capture
  // Falling edge lies half a period after the rise, past the fixed output latency
  always @(negedge sample_clk)
  begin
    cap    <= '{over: bus_flag, word: bus_word};
    cap_ok <= bus_oe && valid;
  end
endmodule

// *** test/adc_output_ctrl_test.sv ***
// Self-checking bench for the converter output block
`timescale 1ns/10ps
module adc_output_ctrl_test;
  import adc_fmt_pkg::*;
  // ==========================================================
  // Signals
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sample_clk;
  logic        power_down_select, output_enable_n, conv_over, conv_under, cap_ok;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        sample_word_bits_oe, overrange_flag, overrange_flag_oe, sample_valid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  mode_level, bresp, rresp;
  logic [13:0] conv_code, sample_word_bits, e;
  logic [2:0]  sdiv;
  sample_bus_s cap;
  int          bad_count, checked, m, k;
  logic [13:0] codes [3] = '{14'h2000, 14'h3FFE, 14'h0001};

  adc_output_ctrl #(.SLEEP_RECOVER_CYCLES(20)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .sample_clk, .mode_level, .power_down_select, .output_enable_n,
    .conv_code, .conv_over, .conv_under, .sample_word_bits, .sample_word_bits_oe, .overrange_flag,
    .overrange_flag_oe, .sample_valid, .irq);
  // A released bus shows the inverse of its last word
  capture_model cap_i (.sample_clk, .bus_word(sample_word_bits_oe ? sample_word_bits : ~sample_word_bits),
    .bus_flag(overrange_flag_oe ? overrange_flag : ~overrange_flag), .bus_oe(sample_word_bits_oe),
    .valid(sample_valid), .cap, .cap_ok);

  always #20 aclk = ~aclk;
  // Eight cycle period, four high and four low: 3.125 Msps at even duty
  always @(posedge aclk)
  begin
    sdiv       <= sdiv + 3'h1;
    sample_clk <= sdiv[2];
  end
  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] s);
    checked++;
    if (s !== ex)
    begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", n, ex, s);
    end
  endtask
  task automatic guard(input int n);
    if (n == 50)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int j;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (j = 0; j < 50; j++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    guard(j);
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    int j;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (j = 0; j < 50; j++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    v = rdata;
    guard(j);
    chk("rresp", er, rresp);
  endtask
  task automatic settle();
    repeat (14) @(posedge aclk);
  endtask
  task automatic recover(input int lo, input int hi);
    int n;
    for (n = 0; n < 1000 && sample_valid !== 1'b1; n++) @(posedge aclk);
    chk("recovery", 1, n > lo && n < hi);
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    aclk = 0; aresetn = 0; sdiv = 0; sample_clk = 0; awaddr = 0; awvalid = 0; wdata = 0; wstrb = 4'hF;
    wvalid = 0; bready = 0; araddr = 0; arvalid = 0; rready = 0; mode_level = 0; power_down_select = 0;
    output_enable_n = 0; conv_code = 0; conv_over = 0; conv_under = 0; bad_count = 0; checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(INT_MASK_OFS, RESP_OKAY, d);
    chk("mask reset", 32'h0, d);
    rd(CTRL_OFS, RESP_OKAY, d);
    chk("ctrl reset", 32'h0, d);
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, RESP_SLVERR, d);
    wr(STATUS_OFS, 32'h0, RESP_SLVERR);
    for (m = 0; m < 4; m++)
    begin
      mode_level <= m[1:0];
      for (k = 0; k < 3; k++)
      begin
        conv_code <= codes[k];
        settle();
        e = codes[k] ^ ((m >= 2) ? 14'h2000 : 14'h0000);
        chk("word", e, sample_word_bits);
        chk("capture", e, cap.word);
      end
      rd(STATUS_OFS, RESP_OKAY, d);
      chk("format", {m == 1 || m == 2, m >= 2}, d[1:0]);
    end
    wr(INT_MASK_OFS, 32'h1, RESP_OKAY);
    conv_code <= 14'h1234; conv_over <= 1'b1;
    settle();
    chk("flag", 1, overrange_flag);
    chk("word", 14'h1FFF, sample_word_bits);
    chk("capture flag", 1, cap.over);
    chk("irq", 1, irq);
    conv_over <= 1'b0; conv_under <= 1'b1;
    settle();
    chk("word", 14'h2000, sample_word_bits);
    mode_level <= 2'h0;
    settle();
    chk("word", 14'h0000, sample_word_bits);
    chk("flag", 1, overrange_flag);
    conv_under <= 1'b0;
    settle();
    chk("flag", 0, overrange_flag);
    wr(INT_STATUS_OFS, 32'h1, RESP_OKAY);
    chk("irq", 0, irq);
    wr(INT_MASK_OFS, 32'h0, RESP_OKAY);
    conv_over <= 1'b1;
    settle();
    chk("irq masked", 0, irq);
    rd(INT_STATUS_OFS, RESP_OKAY, d);
    chk("overrange event", 1, d[0]);
    chk("clock events", 0, d[4:1]);
    conv_over <= 1'b0; output_enable_n <= 1'b1;
    settle();
    chk("word oe", 0, sample_word_bits_oe);
    chk("flag oe", 0, overrange_flag_oe);
    chk("capture ok", 0, cap_ok);
    output_enable_n <= 1'b0;
    settle();
    chk("word oe", 1, sample_word_bits_oe);
    chk("capture ok", 1, cap_ok);
    power_down_select <= 1'b1;
    settle();
    chk("nap oe", 0, sample_word_bits_oe);
    chk("nap valid", 0, sample_valid);
    power_down_select <= 1'b0;
    recover(780, 830);
    power_down_select <= 1'b1;
    output_enable_n <= 1'b1;
    settle();
    power_down_select <= 1'b0;
    output_enable_n <= 1'b0;
    recover(140, 180);
    mode_level <= 2'h1;
    settle();
    chk("relocking", 0, sample_valid);
    recover(760, 800);
    rd(INT_STATUS_OFS, RESP_OKAY, d);
    chk("lock event", 1, d[4]);
    report_and_stop();
  end
endmodule
bind adc_output_ctrl adc_output_checker chk_i (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .arvalid, .arready, .rvalid, .power_down_select, .output_enable_n, .sample_word_bits,
  .sample_word_bits_oe, .overrange_flag, .overrange_flag_oe, .sample_valid);
